// File: memmap_exc_ctrl.sv
// address decode, exception vector sequencing and power control bits
`timescale 1ns/1ps
// Overview of operation
// - heavy-load protection when fast oscillator on outside sleep, or buzzer on
// - regulator level selectable: 3.2, 2.4, 1.6 V
// - 8KB internal ROM, mapped per chip mode
// - RAM split display/data by build option
// - internal RAM range never goes external
// - peripheral registers at FF00H-FFFFH window
// - peripheral window never goes external
// - hardware vectors 00-29H, software 34H-FFH even
// - vector is low byte then high byte
// - priority by level, ties by table order
// - non-reset exceptions push flags and PC
// - fixed vector assignment reset to clock timer
// - vector 32H is never used
// - customized condition flag held inactive
// - chip mode pin high uses internal ROM
// - internal hits drive no external strobes
module memmap_exc_ctrl import memmap_exc_pkg::*; #(
  parameter int DATA_SPLIT = 7,
  parameter int LVL_W = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic chip_mode_pin,
  input wire logic fast_osc_enable,
  input wire logic sleep_active,
  input wire logic buzzer_on,
  input wire logic buzzer_one_shot,
  output logic heavy_load_protect,
  output logic [1:0] core_regulator_output,
  input wire logic [23:0] core_addr,
  input wire logic core_rd,
  input wire logic core_wr,
  output logic sel_rom,
  output logic sel_ram_disp,
  output logic sel_ram_data,
  output logic sel_io,
  output logic sel_ext,
  output logic ext_ce_n,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic ext_data_oe,
  input wire logic exc_boundary,
  input wire logic zero_div_req,
  input wire logic nmi_req,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ*LVL_W-1:0] irq_level,
  input wire logic [LVL_W-1:0] cpu_level,
  input wire logic sw_int_req,
  input wire logic [7:0] sw_int_vec,
  output logic push_req,
  output logic vec_rd,
  output logic [7:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic [15:0] handler_pc,
  output logic handler_valid,
  output logic exc_busy,
  output logic customized_condition_flag
);

  // ************************************************************
  // chip mode capture and address decode
  // ************************************************************
  localparam logic [23:0] DATA_BASE = DATA_TOP - (SPLIT_STEP * 24'(DATA_SPLIT));

  logic mode_mcu_ff;
  logic mode_taken_ff;
  logic in_io, in_ram, in_rom, access;

  // pin caught at the first edge after reset release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_mcu_ff <= 1'b1;
      mode_taken_ff <= 1'b0;
    end else if (!mode_taken_ff) begin
      mode_mcu_ff <= chip_mode_pin;
      mode_taken_ff <= 1'b1;
    end
  end

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    in_io = in_range(core_addr, IO_BASE, IO_LAST);
    in_ram = in_range(core_addr, RAM_BASE, RAM_LAST);
    in_rom = mode_mcu_ff && in_range(core_addr, ROM_BASE, ROM_LAST);
    access = core_rd || core_wr;
    // io and ram take precedence, one target only
    sel_io = access && in_io;
    sel_ram_data = access && !in_io && in_ram && (core_addr >= DATA_BASE);
    sel_ram_disp = access && !in_io && in_ram && (core_addr < DATA_BASE);
    sel_rom = access && !in_io && !in_ram && in_rom;
    sel_ext = access && !in_io && !in_ram && !in_rom;
    ext_ce_n = !sel_ext;
    ext_rd_n = !(sel_ext && core_rd);
    ext_wr_n = !(sel_ext && core_wr);
    ext_data_oe = sel_ext && core_wr;
  end

  // ************************************************************
  // power control
  // ************************************************************
  logic [1:0] reg_sel_ff;
  logic heavy_ff;
  logic nxt_heavy;

  assign nxt_heavy = (fast_osc_enable && !sleep_active) || buzzer_on || buzzer_one_shot;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      heavy_ff <= 1'b0;
    end else begin
      heavy_ff <= nxt_heavy;
    end
  end

  assign heavy_load_protect = heavy_ff;
  assign core_regulator_output = reg_sel_ff;
  assign customized_condition_flag = 1'b0;

  // ************************************************************
  // exception source capture and arbitration
  // ************************************************************
  exc_state_e state_ff;
  logic reset_pend_ff, zero_divide_vector_pend_ff, nmi_pend_ff, sw_pend_ff;
  logic [7:0] sw_vec_ff;
  logic [7:0] cur_vec_ff;
  logic cur_reset_ff;
  logic [7:0] lo_ff;
  logic [15:0] handler_ff;
  logic valid_ff;
  logic [7:0] last_vec_ff;
  logic irq_found;
  logic [$clog2(NUM_IRQ)-1:0] irq_win;
  logic [LVL_W-1:0] best_lvl;
  logic [LVL_W-1:0] lvl_i;
  logic take, sw_ok;
  logic [7:0] win_vec;

  // software vector: even, inside the software area, never the reserved slot
  assign sw_ok = !sw_int_vec[0] && (sw_int_vec >= VEC_SW_FIRST) && (sw_int_vec <= VEC_SW_LAST)
                 && (sw_int_vec != VEC_RESERVED);

  always_comb begin
    irq_found = 1'b0;
    irq_win = '0;
    best_lvl = '0;
    lvl_i = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      lvl_i = irq_level[i*LVL_W +: LVL_W];
      // strict compare keeps the lower vector on equal levels
      if (irq_req[i] && (lvl_i > cpu_level) && (!irq_found || (lvl_i > best_lvl))) begin
        irq_found = 1'b1;
        irq_win = i[$clog2(NUM_IRQ)-1:0];
        best_lvl = lvl_i;
      end
    end
  end

  // fixed order: reset, zero division, NMI, then leveled, then software
  always_comb begin
    take = 1'b1;
    if (reset_pend_ff) begin
      win_vec = VEC_RESET;
    end else if (zero_divide_vector_pend_ff) begin
      win_vec = VEC_ZERO_DIVIDE_VECTOR;
    end else if (nmi_pend_ff) begin
      win_vec = VEC_NMI;
    end else if (irq_found) begin
      win_vec = IRQ_VEC[irq_win];
    end else if (sw_pend_ff) begin
      win_vec = sw_vec_ff;
    end else begin
      win_vec = VEC_RESET;
      take = 1'b0;
    end
  end

  logic start;
  assign start = (state_ff == ST_IDLE) && take && (exc_boundary || reset_pend_ff);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reset_pend_ff <= 1'b1;
      zero_divide_vector_pend_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
      sw_pend_ff <= 1'b0;
      sw_vec_ff <= VEC_SW_FIRST;
    end else begin
      if (start && reset_pend_ff) begin
        reset_pend_ff <= 1'b0;
      end
      // a new request wins over the clear of the one just taken
      zero_divide_vector_pend_ff <= zero_div_req || (zero_divide_vector_pend_ff && !(start && !reset_pend_ff));
      nmi_pend_ff <= nmi_req || (nmi_pend_ff && !(start && !reset_pend_ff && !zero_divide_vector_pend_ff));
      if (sw_int_req && sw_ok) begin
        sw_pend_ff <= 1'b1;
        sw_vec_ff <= sw_int_vec;
      end else if (start && (win_vec == sw_vec_ff) && !reset_pend_ff && !zero_divide_vector_pend_ff
                   && !nmi_pend_ff && !irq_found) begin
        sw_pend_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // vector fetch sequence
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      cur_vec_ff <= VEC_RESET;
      cur_reset_ff <= 1'b0;
      lo_ff <= 8'h00;
      handler_ff <= 16'h0000;
      valid_ff <= 1'b0;
      last_vec_ff <= VEC_RESET;
    end else begin
      valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            cur_vec_ff <= win_vec;
            cur_reset_ff <= reset_pend_ff;
            state_ff <= reset_pend_ff ? ST_FETCH_LO : ST_PUSH;
          end
        end
        ST_PUSH: begin
          state_ff <= ST_FETCH_LO;
        end
        ST_FETCH_LO: begin
          state_ff <= ST_FETCH_HI;
        end
        ST_FETCH_HI: begin
          lo_ff <= vec_data;
          state_ff <= ST_LOAD;
        end
        ST_LOAD: begin
          handler_ff <= {vec_data, lo_ff};
          valid_ff <= 1'b1;
          last_vec_ff <= cur_vec_ff;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign push_req = (state_ff == ST_PUSH);
  assign vec_rd = (state_ff == ST_FETCH_LO) || (state_ff == ST_FETCH_HI);
  assign vec_addr = (state_ff == ST_FETCH_HI) ? {cur_vec_ff[7:1], 1'b1} : cur_vec_ff;
  assign handler_pc = handler_ff;
  assign handler_valid = valid_ff;
  assign exc_busy = (state_ff != ST_IDLE);

  // ************************************************************
  // register bus and interrupt
  // ************************************************************
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_evt;
  logic wr_en, rd_hit;
  logic [31:0] rd_val;

  assign wr_en = psel && penable && pwrite;
  assign irq_evt[IRQ_EXC_TAKEN] = valid_ff;
  assign irq_evt[IRQ_BAD_SWVEC] = sw_int_req && !sw_ok;
  assign irq_evt[IRQ_HEAVY_LOAD] = nxt_heavy && !heavy_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_sel_ff <= REG_3V2;
    end else if (wr_en && (paddr == OFS_CTRL) && (pwdata[1:0] != 2'h3)) begin
      reg_sel_ff <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      // set wins over write-one-clear
      if (wr_en && (paddr == OFS_IRQ_STAT)) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      if (wr_en && (paddr == OFS_IRQ_MASK)) begin
        irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      OFS_CTRL: rd_val = {30'h0, reg_sel_ff};
      OFS_STATUS: rd_val = {28'h0, exc_busy, heavy_ff, mode_taken_ff, mode_mcu_ff};
      OFS_IRQ_STAT: rd_val = {29'h0, irq_stat_ff};
      OFS_IRQ_MASK: rd_val = {29'h0, irq_mask_ff};
      OFS_LAST_VEC: rd_val = {24'h0, last_vec_ff};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign prdata = (psel && penable && !pwrite) ? rd_val : 32'h0;

  // ************************************************************
  // checks
  // ************************************************************
  a_heavy_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    (buzzer_on || buzzer_one_shot) |=> heavy_load_protect)
    else $error("heavy load not raised");
  a_reg_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
    core_regulator_output != 2'h3)
    else $error("regulator setting illegal");
  a_ram_internal: assert property (@(posedge clk_sys) disable iff (!resetn)
    (access && in_range(core_addr, RAM_BASE, IO_LAST)) |-> (ext_ce_n && !ext_data_oe))
    else $error("internal ram or io went external");
  a_io_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    (access && core_addr[23:8] == 16'h00ff) |-> sel_io)
    else $error("io window not selected");
  a_one_target: assert property (@(posedge clk_sys) disable iff (!resetn)
    access |-> $onehot({sel_rom, sel_ram_disp, sel_ram_data, sel_io, sel_ext}))
    else $error("target select not one-hot");
  a_vec_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_ff == ST_FETCH_LO) |=> (vec_addr == {$past(vec_addr[7:1]), 1'b1}) ##1 vec_rd == 1'b0)
    else $error("vector pair order wrong");
  a_push_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    push_req |=> (state_ff == ST_FETCH_LO) ##3 handler_valid)
    else $error("push not followed by fetch");
  a_no_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    vec_rd |-> (vec_addr[7:1] != VEC_RESERVED[7:1]))
    else $error("reserved vector used");
  a_ccf_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    !customized_condition_flag)
    else $error("customized flag active");
  a_mpu_rom_ext: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode_taken_ff && !mode_mcu_ff && access && core_addr <= ROM_LAST) |-> sel_ext)
    else $error("rom range not released");

endmodule

// File: memmap_exc_pkg.sv
// constants shared by the memory map and exception vector block
package memmap_exc_pkg;
  // ************************************************************
  // address map
  // ************************************************************
  localparam logic [23:0] ROM_BASE = 24'h000000;
  localparam logic [23:0] ROM_LAST = 24'h001fff;
  localparam logic [23:0] RAM_BASE = 24'h00f000;
  localparam logic [23:0] RAM_LAST = 24'h00feff;
  localparam logic [23:0] IO_BASE = 24'h00ff00;
  localparam logic [23:0] IO_LAST = 24'h00ffff;
  localparam logic [23:0] SPLIT_STEP = 24'h000100;
  localparam logic [23:0] DATA_TOP = 24'h00ff00;
  localparam int SPLIT_MIN = 1;
  localparam int SPLIT_MAX = 7;
  // ************************************************************
  // exception vectors
  // ************************************************************
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_ZERO_DIVIDE_VECTOR = 8'h02;
  localparam logic [7:0] VEC_NMI = 8'h04;
  localparam logic [7:0] VEC_HW_LAST = 8'h29;
  localparam logic [7:0] VEC_RESERVED = 8'h32;
  localparam logic [7:0] VEC_SW_FIRST = 8'h34;
  localparam logic [7:0] VEC_SW_LAST = 8'hff;
  localparam int NUM_IRQ = 15;
  localparam logic [7:0] IRQ_VEC [NUM_IRQ] = '{
    8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14,
    8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h24, 8'h28};
  // ************************************************************
  // regulator settings: 3.2 V, 2.4 V, 1.6 V
  // ************************************************************
  localparam logic [1:0] REG_3V2 = 2'h0;
  localparam logic [1:0] REG_2V4 = 2'h1;
  localparam logic [1:0] REG_1V6 = 2'h2;
  // ************************************************************
  // register offsets and fields
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LAST_VEC = 8'h10;
  localparam int IRQ_W = 3;
  localparam int IRQ_EXC_TAKEN = 0;
  localparam int IRQ_BAD_SWVEC = 1;
  localparam int IRQ_HEAVY_LOAD = 2;
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_FETCH_LO, ST_FETCH_HI, ST_LOAD} exc_state_e;
endpackage

// File: memmap_exc_vrom_model.sv
// vector rom model answering the block's vector fetches
`timescale 1ns/1ps
module memmap_exc_vrom_model (
  input wire logic clk_sys,
  input wire logic vec_rd,
  input wire logic [7:0] vec_addr,
  output logic [7:0] vec_data
);
  initial vec_data = 8'h00;
  // synchronous rom, one cycle latency; byte at a is a ^ 5a, so low byte at v, high byte at v+1
  // outside a fetch the data toggles so a stale byte is never seen as valid
  always @(posedge clk_sys) begin
    if (vec_rd) begin
      vec_data <= vec_addr ^ 8'h5a;
    end else begin
      vec_data <= ~vec_data;
    end
  end
endmodule

// File: memory_map_exception_vectors_bench.sv
// self-checking bench for the memory map and exception vector block
`timescale 1ns/1ps
module memory_map_exception_vectors_bench import memmap_exc_pkg::*;;
  localparam int SPLIT = 7;
  localparam logic [23:0] ADDRS [12] = '{24'h000000, 24'h001fff, 24'h002000, 24'h00efff, 24'h00f000, 24'h00f7ff,
    24'h00f800, 24'h00feff, 24'h00ff00, 24'h00ffff, 24'h010000, 24'h40f000};
  logic clk_sys = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, irq, chip_mode_pin, fast_osc_enable, sleep_active;
  logic buzzer_on, buzzer_one_shot, heavy_load_protect, core_rd, core_wr, sel_rom, sel_ram_disp, sel_ram_data;
  logic sel_io, sel_ext, ext_ce_n, ext_rd_n, ext_wr_n, ext_data_oe, exc_boundary, zero_div_req, nmi_req;
  logic sw_int_req, push_req, vec_rd, handler_valid, exc_busy, customized_condition_flag;
  logic [7:0] paddr, sw_int_vec, vec_addr, vec_data;
  logic [31:0] pwdata, prdata;
  logic [1:0] core_regulator_output, cpu_level;
  logic [23:0] core_addr;
  logic [14:0] irq_req;
  logic [29:0] irq_level;
  logic [15:0] handler_pc;
  logic [15:0] last_pc = 16'h0000;
  int bad_count = 0;
  int checks = 0;
  always #4 clk_sys = ~clk_sys;
  memmap_exc_ctrl #(.DATA_SPLIT(SPLIT), .LVL_W(2)) uut (.clk_sys, .resetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .irq, .chip_mode_pin, .fast_osc_enable, .sleep_active, .buzzer_on,
    .buzzer_one_shot, .heavy_load_protect, .core_regulator_output, .core_addr, .core_rd, .core_wr, .sel_rom,
    .sel_ram_disp, .sel_ram_data, .sel_io, .sel_ext, .ext_ce_n, .ext_rd_n, .ext_wr_n, .ext_data_oe,
    .exc_boundary, .zero_div_req, .nmi_req, .irq_req, .irq_level, .cpu_level, .sw_int_req, .sw_int_vec,
    .push_req, .vec_rd, .vec_addr, .vec_data, .handler_pc, .handler_valid, .exc_busy, .customized_condition_flag);
  memmap_exc_vrom_model vrom (.clk_sys, .vec_rd, .vec_addr, .vec_data);
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t: bus answer timed out", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, 32'h0, "read error");
  endtask
  task automatic exc(input logic [7:0] v, input logic bnd, input logic sw, input logic pushx);
    logic pushed;
    logic tk;
    pushed = 1'b0;
    // a software vector is refused when odd, below the software area or the reserved slot
    tk = !(sw && (v[0] || v < VEC_SW_FIRST || v == VEC_RESERVED));
    if (tk) last_pc = {(v | 8'h01) ^ 8'h5a, v ^ 8'h5a};
    if (bnd) begin
      @(posedge clk_sys);
      sw_int_req <= sw;
      if (sw) sw_int_vec <= v;
      // request latched first, boundary one cycle later takes it
      @(posedge clk_sys);
      sw_int_req <= 1'b0;
      exc_boundary <= 1'b1;
      @(posedge clk_sys);
      exc_boundary <= 1'b0;
    end
    repeat (30) begin
      #1;
      if (push_req === 1'b1) pushed = 1'b1;
      if (handler_valid === 1'b1) break;
      @(posedge clk_sys);
    end
    chk({31'h0, handler_valid}, {31'h0, tk}, "handler valid");
    chk({16'h0, handler_pc}, {16'h0, last_pc}, "handler pc");
    chk({31'h0, pushed}, {31'h0, pushx}, "push");
  endtask
  function automatic logic [4:0] tgt(input logic [23:0] a, input logic m);
    if (a >= 24'h00ff00) return (a <= 24'h00ffff) ? 5'b00010 : 5'b00001;
    if (a >= 24'h00f000) return (a >= 24'h00ff00 - 24'(SPLIT * 256)) ? 5'b00100 : 5'b01000;
    if (m && a <= 24'h001fff) return 5'b10000;
    return 5'b00001;
  endfunction
  task automatic dec(input logic m);
    logic x;
    for (int i = 0; i < 12; i++) begin
      for (int w = 0; w < 2; w++) begin
        @(posedge clk_sys);
        core_addr <= ADDRS[i];
        core_rd <= (w == 0);
        core_wr <= (w == 1);
        #1;
        x = tgt(ADDRS[i], m) == 5'b00001;
        chk({27'h0, sel_rom, sel_ram_disp, sel_ram_data, sel_io, sel_ext}, {27'h0, tgt(ADDRS[i], m)}, "select");
        chk({28'h0, ext_ce_n, ext_rd_n, ext_wr_n, ext_data_oe},
          x ? {28'h0, 1'b0, w == 1, w == 0, w == 1} : 32'he, "strobes");
      end
    end
    @(posedge clk_sys);
    core_rd <= 1'b0;
    core_wr <= 1'b0;
    #1;
    chk({27'h0, sel_rom, sel_ram_disp, sel_ram_data, sel_io, sel_ext}, 32'h0, "idle select");
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] r;
    logic e;
    {resetn, psel, penable, pwrite, fast_osc_enable, sleep_active, buzzer_on, buzzer_one_shot} = 8'h00;
    {core_rd, core_wr, exc_boundary, zero_div_req, nmi_req, sw_int_req} = 6'h00;
    {paddr, sw_int_vec, pwdata, core_addr, irq_req, irq_level, cpu_level} = '0;
    chip_mode_pin = 1'b1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    exc(8'h00, 1'b0, 1'b0, 1'b0);
    chk({31'h0, customized_condition_flag}, 32'h0, "custom flag");
    dec(1'b1);
    $display("done: decode in internal rom mode");
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'(i));
      rdc(OFS_CTRL, 32'(i));
      chk({30'h0, core_regulator_output}, 32'(i), "regulator");
    end
    wr(OFS_CTRL, 32'h3);
    rdc(OFS_CTRL, 32'h2);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped read");
    chk(r, 32'h0, "unmapped data");
    apb(1'b1, 8'h40, 32'h1, r, e);
    chk({31'h0, e}, 32'h1, "unmapped write");
    $display("done: registers");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      {fast_osc_enable, sleep_active, buzzer_on, buzzer_one_shot} <= 4'(i);
      @(posedge clk_sys);
      #1;
      chk({31'h0, heavy_load_protect}, {31'h0, (i[3] & !i[2]) | i[1] | i[0]}, "heavy load");
    end
    $display("done: heavy load");
    @(posedge clk_sys);
    zero_div_req <= 1'b1;
    nmi_req <= 1'b1;
    irq_req <= 15'h4001;
    irq_level <= 30'h30000001;
    @(posedge clk_sys);
    zero_div_req <= 1'b0;
    nmi_req <= 1'b0;
    exc(VEC_ZERO_DIVIDE_VECTOR, 1'b1, 1'b0, 1'b1);
    exc(VEC_NMI, 1'b1, 1'b0, 1'b1);
    exc(8'h28, 1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    irq_req <= 15'h0001;
    exc(8'h06, 1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    irq_req <= 15'h2002;
    irq_level <= 30'h08000008;
    exc(8'h08, 1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    irq_req <= 15'h0000;
    $display("done: priority");
    sw_int_vec <= VEC_SW_FIRST;
    exc(VEC_SW_FIRST, 1'b1, 1'b1, 1'b1);
    wr(OFS_IRQ_STAT, 32'h7);
    rdc(OFS_IRQ_STAT, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      sw_int_vec <= VEC_RESERVED + 8'(i);
      exc(VEC_RESERVED + 8'(i), 1'b1, 1'b1, 1'b0);
      chk({31'h0, exc_busy}, 32'h0, "refused vector busy");
      rdc(OFS_IRQ_STAT, 32'h2);
      wr(OFS_IRQ_STAT, 32'h2);
    end
    rdc(OFS_LAST_VEC, {24'h0, VEC_SW_FIRST});
    $display("done: software vectors");
    wr(OFS_IRQ_MASK, 32'h1);
    exc(8'h34, 1'b1, 1'b1, 1'b1);
    @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(OFS_IRQ_STAT, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(OFS_IRQ_MASK, 32'h0);
    $display("done: interrupt");
    @(posedge clk_sys);
    resetn <= 1'b0;
    chip_mode_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    exc(8'h00, 1'b0, 1'b0, 1'b0);
    dec(1'b0);
    $display("done: external rom mode");
    give_verdict();
  end
  initial begin
    #80000;
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
